// ---- port_pwr_pkg.sv ----
// Purpose: Shared constants for downstream port power and over-current control
// Assumes: Core clock at 250 MHz, one sense tick every microsecond
// Notes: Times kept in printed units, tick counts derived below
package port_pwr_pkg;

    localparam int CLK_MHZ = 250;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1000000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = TICK_NS * CLK_MHZ / NS_PER_US;

    // Single low pulse is a least time: round up
    localparam int OCS_SINGLE_MS = 5;
    localparam int OCS_SINGLE_TICKS = (OCS_SINGLE_MS * NS_PER_MS + TICK_NS - 1) / TICK_NS;

    // Double pulse window is a longest time: round down
    localparam int OCS_DOUBLE_MS = 20;
    localparam int OCS_DOUBLE_TICKS = OCS_DOUBLE_MS * NS_PER_MS / TICK_NS;

    // Inrush blanking after power is applied
    localparam int OCS_BLANK_US = 100;
    localparam int OCS_BLANK_TICKS = OCS_BLANK_US * NS_PER_US / TICK_NS;

    localparam int NUM_PORTS = 2;
    localparam int CNT_W = 16;
    localparam int DIV_W = 8;

    localparam logic PIN_IDLE = 1'b1;
    localparam logic PIN_DRIVE_VAL = 1'b0;

endpackage : port_pwr_pkg

// ---- port_power_overcurrent_ctrl.sv ----
// Purpose: Port power switching and filtered over-current sensing on shared pins
// Assumes: Pin inputs asynchronous; all control inputs on i_core_clk
// Notes: Open-drain pins are split into input, output and output enable
//
// Notes on behaviour
// [R1] Combined mode: one pin per port carries power enable and over-current sense.
// [R2] Power off: drive pin low and switch its pull-up off; the code releases pins with pull-up off until the first clock after reset.
// [R3] Power on: release driver, enable pull-up, pin reads high.
// [R4] External switch pulls line low on over-current; read through input buffer.
// [R5] While enabled, pin level is sampled continuously for over-current detection.
// [R6] Uninterrupted low samples for the single-pulse time flag over-current.
// [R7] Two separate low groups within the rolling double window flag over-current.
// [R8] Transient lows during power-up must not cause false over-current events.
// [R9] Ganged mode: one shared pin controls power and senses for all ports.
// [R10] Power and over-current controllable by hub logic or by the processor.
// [R11] Battery charging ports indicate high-current supply on their own pin; the code drives o_bc_supply_ind in combined mode only, low in ganged mode.
// [R12] Single low pulse must last at least five milliseconds.
// [R13] Double pulse rolling window is at most twenty milliseconds.
// [R14] Over-current latches a per-port flag and removes power until cleared.
module port_power_overcurrent_ctrl
    import port_pwr_pkg::*;
#(
    parameter int NPORTS = port_pwr_pkg::NUM_PORTS,
    parameter int TICK_CYC = port_pwr_pkg::TICK_CYCLES,
    parameter int SINGLE_TICKS = port_pwr_pkg::OCS_SINGLE_TICKS,
    parameter int DOUBLE_TICKS = port_pwr_pkg::OCS_DOUBLE_TICKS,
    parameter int BLANK_TICKS = port_pwr_pkg::OCS_BLANK_TICKS
)
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Mode selection
    input wire logic i_ganged_mode,
    input wire logic i_cpu_ctrl_sel,
    // Per-port requests from hub logic and processor
    input wire logic [NPORTS-1:0] i_hub_pwr_req,
    input wire logic [NPORTS-1:0] i_cpu_pwr_req,
    input wire logic [NPORTS-1:0] i_hub_oc_clear,
    input wire logic [NPORTS-1:0] i_cpu_oc_clear,
    input wire logic [NPORTS-1:0] i_bc_enable,
    // Per-port power and sense pins
    input wire logic [NPORTS-1:0] i_port_power_sense_pin,
    output logic [NPORTS-1:0] o_port_power_sense_pin_o,
    output logic [NPORTS-1:0] o_port_power_sense_pin_oe,
    output logic [NPORTS-1:0] o_port_pullup_en,
    // Shared pin for ganged mode
    input wire logic i_shared_power_sense_pin,
    output logic o_shared_power_sense_pin_o,
    output logic o_shared_power_sense_pin_oe,
    output logic o_shared_pullup_en,
    // Status
    output logic [NPORTS-1:0] o_port_power_on,
    output logic [NPORTS-1:0] o_oc_flag,
    output logic [NPORTS-1:0] o_oc_event,
    output logic [NPORTS-1:0] o_bc_supply_ind
);
    import port_pwr_pkg::*;

    localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYC - 1);
    localparam logic [CNT_W-1:0] SINGLE_LIM = CNT_W'(SINGLE_TICKS);
    localparam logic [CNT_W-1:0] DOUBLE_LIM = CNT_W'(DOUBLE_TICKS);
    localparam logic [CNT_W-1:0] BLANK_LIM = CNT_W'(BLANK_TICKS);

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
        sat_inc = (v >= lim) ? lim : CNT_W'(v + 1'b1);
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and sense tick
    logic [NPORTS-1:0] port_meta_q, port_meta_d, port_sync_q, port_sync_d;
    logic shared_meta_q, shared_meta_d, shared_sync_q, shared_sync_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;

    always_comb
    begin
        port_meta_d = i_port_power_sense_pin; // R4
        port_sync_d = port_meta_q;
        shared_meta_d = i_shared_power_sense_pin;
        shared_sync_d = shared_meta_q;
        tick_d = (div_q == TICK_LAST);
        div_d = tick_d ? '0 : DIV_W'(div_q + 1'b1);
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            port_meta_q <= {NPORTS{PIN_IDLE}};
            port_sync_q <= {NPORTS{PIN_IDLE}};
            shared_meta_q <= PIN_IDLE;
            shared_sync_q <= PIN_IDLE;
            div_q <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            port_meta_q <= port_meta_d;
            port_sync_q <= port_sync_d;
            shared_meta_q <= shared_meta_d;
            shared_sync_q <= shared_sync_d;
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Over-current detection, one channel per port; channel 0 serves the shared pin
    logic [NPORTS-1:0] port_on_q, port_on_d, oc_q, oc_d, ev_q, ev_d;
    logic shared_on_q, shared_on_d;
    logic [NPORTS-1:0] prev_low_q, prev_low_d, first_q, first_d;
    logic [CNT_W-1:0] low_cnt_q [NPORTS];
    logic [CNT_W-1:0] low_cnt_d [NPORTS];
    logic [CNT_W-1:0] win_q [NPORTS];
    logic [CNT_W-1:0] win_d [NPORTS];
    logic [CNT_W-1:0] blank_q [NPORTS];
    logic [CNT_W-1:0] blank_d [NPORTS];
    logic [NPORTS-1:0] det, set, clr, req;
    logic ch_active, ch_low;

    always_comb
    begin
        ch_active = 1'b0;
        ch_low = 1'b0;
        det = '0;
        for (int ch = 0; ch < NPORTS; ch++)
        begin
            // Ganged mode senses only the shared pin on channel 0
            if (i_ganged_mode)
            begin
                ch_active = (ch == 0) && shared_on_q; // R9
                ch_low = ~shared_sync_q;
            end
            else
            begin
                ch_active = port_on_q[ch]; // R1
                ch_low = ~port_sync_q[ch];
            end
            low_cnt_d[ch] = low_cnt_q[ch];
            win_d[ch] = win_q[ch];
            blank_d[ch] = blank_q[ch];
            prev_low_d[ch] = prev_low_q[ch];
            first_d[ch] = first_q[ch];
            if (!ch_active)
            begin
                // Idle channel forgets all history
                low_cnt_d[ch] = '0;
                win_d[ch] = '0;
                blank_d[ch] = '0;
                prev_low_d[ch] = 1'b0;
                first_d[ch] = 1'b0;
            end
            else if (tick_q && blank_q[ch] < BLANK_LIM)
            begin
                blank_d[ch] = sat_inc(blank_q[ch], BLANK_LIM); // R8
            end
            else if (tick_q)
            begin
                // Sampled every tick while powered, once blanking has ended
                prev_low_d[ch] = ch_low; // R5
                low_cnt_d[ch] = ch_low ? sat_inc(low_cnt_q[ch], SINGLE_LIM) : '0;
                if (ch_low && low_cnt_d[ch] >= SINGLE_LIM)
                    det[ch] = 1'b1; // R6 R12
                if (first_q[ch])
                begin
                    win_d[ch] = sat_inc(win_q[ch], DOUBLE_LIM);
                    if (win_d[ch] >= DOUBLE_LIM)
                        first_d[ch] = 1'b0; // R13
                end
                if (ch_low && !prev_low_q[ch])
                begin
                    // New low group: second one inside the window trips
                    if (first_q[ch] && win_q[ch] < DOUBLE_LIM)
                        det[ch] = 1'b1; // R7 R13
                    else
                    begin
                        first_d[ch] = 1'b1;
                        win_d[ch] = '0;
                    end
                end
            end
        end
    end

    always_comb
    begin
        for (int p = 0; p < NPORTS; p++)
        begin
            // Processor takes over power and clear when selected
            req[p] = (i_cpu_ctrl_sel ? i_cpu_pwr_req[p] : i_hub_pwr_req[p]) | i_bc_enable[p]; // R10 R11
            clr[p] = i_cpu_ctrl_sel ? i_cpu_oc_clear[p] : i_hub_oc_clear[p]; // R10
            set[p] = i_ganged_mode ? det[0] : det[p];
        end
        // Set beats clear in the same cycle
        oc_d = set | (oc_q & ~clr); // R14
        ev_d = set;
        port_on_d = i_ganged_mode ? '0 : (req & ~oc_d); // R14
        shared_on_d = i_ganged_mode && (|req) && !(|oc_d); // R9 R14
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            port_on_q <= '0;
            shared_on_q <= 1'b0;
            oc_q <= '0;
            ev_q <= '0;
            prev_low_q <= '0;
            first_q <= '0;
            for (int ch = 0; ch < NPORTS; ch++)
            begin
                low_cnt_q[ch] <= '0;
                win_q[ch] <= '0;
                blank_q[ch] <= '0;
            end
        end
        else
        begin
            port_on_q <= port_on_d;
            shared_on_q <= shared_on_d;
            oc_q <= oc_d;
            ev_q <= ev_d;
            prev_low_q <= prev_low_d;
            first_q <= first_d;
            for (int ch = 0; ch < NPORTS; ch++)
            begin
                low_cnt_q[ch] <= low_cnt_d[ch];
                win_q[ch] <= win_d[ch];
                blank_q[ch] <= blank_d[ch];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, registered so outputs come straight from flops
    logic [NPORTS-1:0] pin_oe_q, pin_oe_d, pull_q, pull_d, bc_q, bc_d;
    logic sh_oe_q, sh_oe_d, sh_pull_q, sh_pull_d;
    logic [NPORTS-1:0] pwr_q, pwr_d;

    always_comb
    begin
        // Unused pin set stays released with pull-up off
        pin_oe_d = i_ganged_mode ? '0 : ~port_on_d; // R2 R3
        pull_d = i_ganged_mode ? '0 : port_on_d; // R2 R3
        sh_oe_d = i_ganged_mode && !shared_on_d; // R9 R2
        sh_pull_d = shared_on_d; // R9 R3
        bc_d = i_ganged_mode ? '0 : (i_bc_enable & port_on_d); // R11
        // Registered so the status never follows the mode input combinationally
        pwr_d = i_ganged_mode ? {NPORTS{shared_on_d}} : port_on_d; // R9
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            pin_oe_q <= '0;
            pull_q <= '0;
            sh_oe_q <= 1'b0;
            sh_pull_q <= 1'b0;
            bc_q <= '0;
            pwr_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_d;
            pin_oe_q <= pin_oe_d;
            pull_q <= pull_d;
            sh_oe_q <= sh_oe_d;
            sh_pull_q <= sh_pull_d;
            bc_q <= bc_d;
        end
    end

    // Driven value is always low; only the enable moves
    assign o_port_power_sense_pin_o = {NPORTS{PIN_DRIVE_VAL}};
    assign o_shared_power_sense_pin_o = PIN_DRIVE_VAL;
    assign o_port_power_sense_pin_oe = pin_oe_q;
    assign o_port_pullup_en = pull_q;
    assign o_shared_power_sense_pin_oe = sh_oe_q;
    assign o_shared_pullup_en = sh_pull_q;
    assign o_port_power_on = pwr_q;
    assign o_oc_flag = oc_q;
    assign o_oc_event = ev_q;
    assign o_bc_supply_ind = bc_q;

endmodule : port_power_overcurrent_ctrl

// ---- port_pwr_chk_assertions.sv ----
// Purpose: Concurrent checks on port power and over-current pins
// Assumes: Combined-mode checks look at port 0 only
// Notes: Bound from the bench top file
module port_pwr_chk_assertions
#(parameter int NPORTS = 2, parameter int TICK_CYC = 4, parameter int SINGLE_TICKS = 10, parameter int BLANK_TICKS = 2)
(
    // Clock, reset and controls
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_ganged_mode,
    input wire logic i_cpu_ctrl_sel,
    input wire logic [NPORTS-1:0] i_hub_oc_clear,
    input wire logic [NPORTS-1:0] i_port_power_sense_pin,
    // Watched outputs
    input wire logic [NPORTS-1:0] o_port_power_sense_pin_oe,
    input wire logic [NPORTS-1:0] o_port_pullup_en,
    input wire logic [NPORTS-1:0] o_port_power_on,
    input wire logic [NPORTS-1:0] o_oc_flag,
    input wire logic [NPORTS-1:0] o_oc_event
);
    timeunit 1ns;
    timeprecision 1ps;
    // Slack covers blanking, synchroniser and tick phase
    localparam int LIM = (SINGLE_TICKS + BLANK_TICKS + 3) * TICK_CYC + 4;
    // Wide enough for the full-size tick counts as well
    logic [31:0] low_q;
    logic [31:0] low_d;
    always_comb
        low_d = (o_port_power_on[0] && !i_ganged_mode && !i_port_power_sense_pin[0]) ? low_q + 32'h00000001 : 32'h00000000;
    always_ff @(posedge i_core_clk)
        low_q <= i_sys_rst ? 32'h00000000 : low_d;
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_quiet;
        !o_oc_event[0] [*8];
    endsequence
    AST_OFF_DRIVE: assert property (!i_ganged_mode && !$past(i_ganged_mode) && !$past(i_sys_rst, 2)
        |-> o_port_power_sense_pin_oe[0] == !o_port_power_on[0]) else $error("drive not tied to power off");
    AST_ON_PULLUP: assert property (!i_ganged_mode && !$past(i_ganged_mode) && !$past(i_sys_rst, 2)
        |-> o_port_pullup_en[0] == o_port_power_on[0]) else $error("pullup not tied to power on");
    AST_FLAG_OFF: assert property (o_oc_flag[0] |-> !o_port_power_on[0])
        else $error("power on with flag set");
    AST_EVENT_SETS: assert property (o_oc_event[0] |-> o_oc_flag[0] ##1 !o_oc_event[0])
        else $error("event without flag or too long");
    AST_BLANK: assert property ($rose(o_port_power_on[0]) |-> ##1 s_quiet)
        else $error("event inside power-up blanking");
    AST_SINGLE_BOUND: assert property (low_q < 32'(LIM))
        else $error("long low pulse not flagged");
    AST_CLEAR: assert property (o_oc_flag[0] && i_hub_oc_clear[0] && !i_cpu_ctrl_sel |=> !o_oc_flag[0])
        else $error("clear did not drop flag");
    AST_GANG_REL: assert property (i_ganged_mode && $past(i_ganged_mode)
        |-> o_port_pullup_en == '0 && o_port_power_sense_pin_oe == '0) else $error("port pins held in ganged mode");
endmodule : port_pwr_chk_assertions

// ---- ext_power_switch.sv ----
// Purpose: External power switch model with open-drain fault output
// Assumes: Fault request comes from the bench
// Notes: A floating pin toggles so no stale level can be read
module ext_power_switch
(
    // Hub side pin controls
    input wire logic i_core_clk,
    input wire logic i_drive_oe,
    input wire logic i_drive_val,
    input wire logic i_pullup_en,
    // Fault request and resolved pin
    input wire logic i_fault,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic float_q = 1'b0;
    always @(posedge i_core_clk)
        float_q <= ~float_q;
    // Switch pulls low on fault; otherwise the hub's driven value shows, or the pull-up or the toggling float when not driven
    assign o_pin = i_fault ? 1'b0 : (i_drive_oe ? i_drive_val : (i_pullup_en ? 1'b1 : float_q));
endmodule : ext_power_switch

// ---- test_port_power_overcurrent_ctrl.sv ----
// Purpose: Self-checking bench for port power and over-current control
// Assumes: Short tick and pulse counts set below
// Notes: Random requests plus hand-made pulse corner cases
module test_port_power_overcurrent_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4, SG = 10, DB = 40, BL = 2;
    logic clk = 1'b0, rst = 1'b1, gang = 1'b0, sel = 1'b0, shf = 1'b0;
    logic [1:0] hreq = 2'h0, creq = 2'h0, hclr = 2'h0, cclr = 2'h0, bc = 2'h0, flt = 2'h0;
    logic [1:0] pin, oe, pu, pwr, flag, evt, bci;
    logic shp, shoe, shpu, shv;
    logic [1:0] pv;
    logic [3:0] ev_cnt = 4'h0;
    int err_count = 0, comparisons = 0, cyc = 0;
    integer seed = 67309;
    port_power_overcurrent_ctrl #(.TICK_CYC(TK), .SINGLE_TICKS(SG), .DOUBLE_TICKS(DB), .BLANK_TICKS(BL)) dut (
        .i_core_clk(clk), .i_sys_rst(rst), .i_ganged_mode(gang), .i_cpu_ctrl_sel(sel),
        .i_hub_pwr_req(hreq), .i_cpu_pwr_req(creq), .i_hub_oc_clear(hclr), .i_cpu_oc_clear(cclr),
        .i_bc_enable(bc), .i_port_power_sense_pin(pin), .o_port_power_sense_pin_o(pv),
        .o_port_power_sense_pin_oe(oe), .o_port_pullup_en(pu), .i_shared_power_sense_pin(shp),
        .o_shared_power_sense_pin_o(shv), .o_shared_power_sense_pin_oe(shoe), .o_shared_pullup_en(shpu),
        .o_port_power_on(pwr), .o_oc_flag(flag), .o_oc_event(evt), .o_bc_supply_ind(bci));
    ext_power_switch sw0 (.i_core_clk(clk), .i_drive_oe(oe[0]), .i_drive_val(pv[0]), .i_pullup_en(pu[0]),
        .i_fault(flt[0]), .o_pin(pin[0]));
    ext_power_switch sw1 (.i_core_clk(clk), .i_drive_oe(oe[1]), .i_drive_val(pv[1]), .i_pullup_en(pu[1]),
        .i_fault(flt[1]), .o_pin(pin[1]));
    ext_power_switch sws (.i_core_clk(clk), .i_drive_oe(shoe), .i_drive_val(shv), .i_pullup_en(shpu),
        .i_fault(shf), .o_pin(shp));
    ////////////////////////////////////////////////////////////
    initial
    begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        // Event pulses last one cycle, so every edge counts them once
        if (!rst)
            ev_cnt <= ev_cnt + {3'h0, evt[0]} + {3'h0, evt[1]};
        if (cyc == 3000)
        begin
            err_count++;
            $display("unexpected at %0t: timeout", $time);
            report_and_stop();
        end
    end
    function automatic logic [1:0] exp_pwr(input logic s, input logic [1:0] h, input logic [1:0] c, input logic [1:0] b);
        return (s ? c : h) | b;
    endfunction : exp_pwr
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %b want %b", $time, got, exp);
        end
    endtask : chk
    task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: event count %h want %h", $time, got, exp);
        end
    endtask : chk_cnt
    // Bounded wait, caller compares afterwards
    task automatic wait_flag(input logic [1:0] want, input int lim);
        repeat (lim)
            if (flag !== want)
                step(1);
    endtask : wait_flag
    task automatic pulse(input int n);
        flt[0] = 1'b1;
        step(n);
        flt[0] = 1'b0;
    endtask : pulse
    task automatic report_and_stop();
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial
    begin
        step(4);
        rst = 1'b0;
        step(3);
        chk(pwr, 2'h0);
        chk(oe, 2'h3);
        repeat (24)
        begin
            {sel, hreq, creq, bc} = 7'($random(seed));
            step(2);
            chk(pwr, exp_pwr(sel, hreq, creq, bc));
            chk(pin, exp_pwr(sel, hreq, creq, bc));
            chk(bci, bc);
        end
        {sel, hreq, creq, bc} = 7'h00;
        step(2);
        hreq = 2'h3;
        pulse(2);
        step((DB + 2) * TK);
        chk(flag, 2'h0);
        flt[0] = 1'b1;
        step((SG - 1) * TK);
        chk(flag, 2'h0);
        wait_flag(2'h1, 4 * TK);
        chk(flag, 2'h1);
        flt[0] = 1'b0;
        step(4 * TK);
        chk(flag, 2'h1);
        chk(pwr, 2'h2);
        chk_cnt(ev_cnt, 4'h1);
        hclr = 2'h1;
        step(1);
        hclr = 2'h0;
        step(1);
        chk(flag, 2'h0);
        chk(pwr, 2'h3);
        step((BL + 2) * TK);
        pulse(2 * TK);
        step((DB + 4) * TK);
        pulse(2 * TK);
        step(4 * TK);
        chk(flag, 2'h0);
        pulse(2 * TK);
        wait_flag(2'h1, 4 * TK);
        chk(flag, 2'h1);
        hclr = 2'h1;
        step(1);
        {hclr, gang, hreq} = 5'h05;
        step((BL + 3) * TK);
        chk(oe | pu, 2'h0);
        chk({shpu, shoe}, 2'h2);
        chk(pwr, 2'h3);
        chk_cnt(ev_cnt, 4'h2);
        shf = 1'b1;
        wait_flag(2'h3, (SG + 4) * TK);
        chk(flag, 2'h3);
        {shf, sel, creq, cclr} = 6'h1F;
        step(1);
        cclr = 2'h0;
        step(1);
        chk(flag, 2'h0);
        chk_cnt(ev_cnt, 4'h4);
        report_and_stop();
    end
endmodule : test_port_power_overcurrent_ctrl

bind port_power_overcurrent_ctrl port_pwr_chk_assertions #(.NPORTS(NPORTS), .TICK_CYC(TICK_CYC),
    .SINGLE_TICKS(SINGLE_TICKS), .BLANK_TICKS(BLANK_TICKS)) chk (.*);
